// *** kis_pkg.sv ***
// Package for the keypad interrupt status block: register offsets, bit positions, resets.
// Assumes an 8-bit register port from a serial slave front end elsewhere in the device.
package kis_pkg;
  localparam logic [7:0] KIS_ADDR_RAW = 8'h06;
  localparam logic [7:0] KIS_ADDR_MASKED = 8'h07;
  localparam logic [7:0] KIS_ADDR_CLEAR = 8'h08;
  localparam logic [7:0] KIS_ADDR_MASK = 8'h09;
  localparam logic [7:0] KIS_ADDR_CODE0 = 8'h0b;
  localparam logic [7:0] KIS_ADDR_CODE3 = 8'h0e;
  localparam int KIS_BIT_SCAN = 0;
  localparam int KIS_BIT_KEY_LOST = 1;
  localparam int KIS_BIT_KEY_EVENT = 2;
  localparam int KIS_BIT_EVENT_LOST = 3;
  localparam int KIS_BIT_CLR_SCAN = 0;
  localparam int KIS_BIT_CLR_EVENT = 1;
  localparam int KIS_BIT_SF_OFF = 7;
  localparam logic [3:0] KIS_RAW_RESET = 4'h0;
  localparam logic [3:0] KIS_MASK_RESET = 4'h3;
  localparam int KIS_EVENT_LIMIT = 8;
  localparam int KIS_KEY_LIMIT = 4;

  // Register access from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kis_bus_t;

  // Event reports from the key scanner and event buffer.
  typedef struct packed {
    logic scan_done;
    logic scan_changed;
    logic new_key_event;
    logic [3:0] keys_down;
    logic buffer_overflow;
    logic buffer_nonempty;
  } kis_scan_t;
endpackage : kis_pkg

// *** kis_code_read_tracker.sv ***
// Tracks reads of the four key-code registers and pulses when all have been read.
// Assumes one-cycle read strobes with a stable address.
`timescale 1ns/1ns
`default_nettype none
module kis_code_read_tracker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Read strobe and address
  input wire logic rd,
  input wire logic [7:0] addr,
  // Any write to the clear register restarts the sequence
  input wire logic restart,
  // One-cycle pulse after the last code register is read
  output logic all_read
);
  import kis_pkg::*;

  logic [3:0] seen;
  logic [3:0] next_seen;
  logic next_all_read;

  always_comb begin
    next_seen = seen;
    next_all_read = 1'b0;
    if (restart) begin
      next_seen = 4'h0;
    end else if (rd && addr >= KIS_ADDR_CODE0 && addr <= KIS_ADDR_CODE3) begin
      next_seen[2'(addr - KIS_ADDR_CODE0)] = 1'b1;
    end
    // Reading in any order counts; the sweep restarts after it completes.
    if (!restart && &next_seen) begin
      next_all_read = 1'b1;
      next_seen = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 4'h0;
      all_read <= 1'b0;
    end else begin
      seen <= next_seen;
      all_read <= next_all_read;
    end
  end
endmodule : kis_code_read_tracker
`default_nettype wire

// *** kis_top.sv ***
// Keypad interrupt status, mask and clear registers with the interrupt request output.
// Assumes a register port from the device's serial slave and event pulses from the scanner.
// Behaviour
// - Event-lost flag sets on event buffer overflow past 8; held until buffer clear.
// - Key-event flag follows buffer non-empty; clear bit 1 drains it.
// - Key-lost flag sets on new key while scan flag set, or over 4 keys.
// - Scan flag sets at scan end when keyboard status changed.
// - Raw status read-only at 0x06, flags reset zero, bits 7:4 read zero.
// - Masked status read-only at 0x07, raw flags gated by mask.
// - Clear register write-only at 0x08, ones clear matching interrupts.
// - Clear bit 1 empties event buffer and clears key-event and event-lost flags.
// - Clear bit 0 clears scan and key-lost flags.
// - Clear bit 7 set skips special-function key scanning; zero scans them.
// - Mask at 0x09, one per source, 1 blocks; bits 1,0 default 1.
// - Reading all four key-code registers clears the scan flag.
`timescale 1ns/1ns
`default_nettype none
module kis_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire kis_pkg::kis_bus_t bus,
  output logic [7:0] rdata,
  // Scanner and event buffer
  input wire kis_pkg::kis_scan_t scan,
  output logic event_buffer_clear,
  output logic special_key_scan_disable,
  // Interrupt request, active high
  output logic irq
);
  import kis_pkg::*;

  logic [3:0] raw;
  logic [3:0] mask;
  logic [3:0] next_raw;
  logic [3:0] next_mask;
  logic next_sf_off;
  logic next_evt_clr;
  logic next_irq;
  logic [7:0] next_rdata;
  logic clr_wr;
  logic clr_scan;
  logic clr_event;
  logic codes_read;
  logic [3:0] masked;

  kis_code_read_tracker u_tracker (
    .clk(clk),
    .reset_n(reset_n),
    .rd(bus.rd),
    .addr(bus.addr),
    .restart(clr_wr),
    .all_read(codes_read)
  );

  assign clr_wr = bus.wr && bus.addr == KIS_ADDR_CLEAR;
  assign clr_scan = (clr_wr && bus.wdata[KIS_BIT_CLR_SCAN]) || codes_read;
  assign clr_event = clr_wr && bus.wdata[KIS_BIT_CLR_EVENT];
  assign masked = raw & ~mask;

  always_comb begin
    next_raw = raw;
    // Clears go first so that an event in the same cycle still sets the flag.
    if (clr_scan) begin
      next_raw[KIS_BIT_SCAN] = 1'b0;
      next_raw[KIS_BIT_KEY_LOST] = 1'b0;
    end
    if (clr_event) begin
      next_raw[KIS_BIT_EVENT_LOST] = 1'b0;
    end
    if (scan.buffer_overflow) begin
      next_raw[KIS_BIT_EVENT_LOST] = 1'b1;
    end
    // The buffer level is tracked live; a clear empties it, so it drops too.
    // The buffer only empties on the edge that sees the clear pulse, so the flag is held
    // low through that cycle as well; otherwise the stale level would raise the interrupt.
    next_raw[KIS_BIT_KEY_EVENT] = scan.buffer_nonempty && !clr_event
        && !event_buffer_clear;
    if ((scan.new_key_event && raw[KIS_BIT_SCAN])
        || 32'(scan.keys_down) > KIS_KEY_LIMIT) begin
      next_raw[KIS_BIT_KEY_LOST] = 1'b1;
    end
    if (scan.scan_done && scan.scan_changed) begin
      next_raw[KIS_BIT_SCAN] = 1'b1;
    end
  end

  always_comb begin
    next_mask = mask;
    next_sf_off = special_key_scan_disable;
    next_evt_clr = clr_event;
    if (bus.wr && bus.addr == KIS_ADDR_MASK) begin
      next_mask = bus.wdata[3:0];
    end
    if (clr_wr) begin
      next_sf_off = bus.wdata[KIS_BIT_SF_OFF];
    end
  end

  always_comb begin
    next_irq = |(next_raw & ~next_mask);
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        KIS_ADDR_RAW: next_rdata = {4'h0, raw};
        KIS_ADDR_MASKED: next_rdata = {4'h0, masked};
        KIS_ADDR_MASK: next_rdata = {4'h0, mask};
        // The clear register is write-only and reads back as zero.
        default: next_rdata = 8'h00;
      endcase
    end else begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw <= KIS_RAW_RESET;
      mask <= KIS_MASK_RESET;
      special_key_scan_disable <= 1'b0;
      event_buffer_clear <= 1'b0;
      irq <= 1'b0;
      rdata <= 8'h00;
    end else begin
      raw <= next_raw;
      mask <= next_mask;
      special_key_scan_disable <= next_sf_off;
      event_buffer_clear <= next_evt_clr;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence scan_end_changed_s;
    scan.scan_done && scan.scan_changed;
  endsequence

  scan_flag_set_a: assert property (scan_end_changed_s |=> raw[KIS_BIT_SCAN])
    else $error("scan flag not set after changed scan");
  overflow_set_a: assert property (scan.buffer_overflow |=> raw[KIS_BIT_EVENT_LOST])
    else $error("event lost flag not set on overflow");
  lost_hold_a: assert property (raw[KIS_BIT_EVENT_LOST] && !clr_event
      |=> raw[KIS_BIT_EVENT_LOST])
    else $error("event lost flag dropped without clear");
  keylost_set_a: assert property (scan.new_key_event && raw[KIS_BIT_SCAN]
      |=> raw[KIS_BIT_KEY_LOST])
    else $error("key lost flag not set");
  clear_scan_a: assert property (clr_scan && !(scan.scan_done && scan.scan_changed)
      |=> !raw[KIS_BIT_SCAN])
    else $error("scan flag not cleared");
  clear_event_a: assert property (clr_event
      |=> event_buffer_clear && !raw[KIS_BIT_KEY_EVENT])
    else $error("event clear not applied");
  irq_follow_a: assert property (##1 irq == |(raw & ~mask))
    else $error("irq does not match masked status");
  raw_read_a: assert property (bus.rd && bus.addr == KIS_ADDR_RAW
      |=> rdata == {4'h0, $past(raw)})
    else $error("raw status read mismatch");
  sf_off_a: assert property (clr_wr
      |=> special_key_scan_disable == $past(bus.wdata[KIS_BIT_SF_OFF]))
    else $error("special key scan option not stored");

  // Clearing and its exceptions: a clear loses only to an event in the same cycle.
  sequence key_overload_s;
    scan.keys_down > 4'(KIS_KEY_LIMIT);
  endsequence

  sequence code_sweep_done_s;
    bus.rd ##1 codes_read && !(scan.scan_done && scan.scan_changed);
  endsequence

  sequence scan_clear_write_s;
    clr_wr && bus.wdata[KIS_BIT_CLR_SCAN];
  endsequence

  keylost_limit_a: assert property (key_overload_s |=> raw[KIS_BIT_KEY_LOST])
    else $error("key lost flag not set on too many keys");
  clear_keylost_a: assert property (clr_scan
      && !(scan.new_key_event && raw[KIS_BIT_SCAN])
      && !(scan.keys_down > 4'(KIS_KEY_LIMIT)) |=> !raw[KIS_BIT_KEY_LOST])
    else $error("key lost flag not cleared");
  overflow_wins_a: assert property (scan.buffer_overflow && clr_event
      |=> raw[KIS_BIT_EVENT_LOST])
    else $error("overflow lost to a same-cycle clear");
  zero_write_a: assert property (clr_wr && !bus.wdata[KIS_BIT_CLR_SCAN]
      && !codes_read && raw[KIS_BIT_SCAN] |=> raw[KIS_BIT_SCAN])
    else $error("scan flag dropped by a zero write");
  code_sweep_a: assert property (code_sweep_done_s |=> !raw[KIS_BIT_SCAN])
    else $error("scan flag not cleared after key code reads");
  sweep_restart_a: assert property (scan_clear_write_s |=> !codes_read)
    else $error("key code sweep not restarted by clear write");

  // The key event flag mirrors the buffer, except while a clear is emptying it.
  event_follow_a: assert property (scan.buffer_nonempty && !clr_event
      && !event_buffer_clear |=> raw[KIS_BIT_KEY_EVENT])
    else $error("key event flag not set while buffer holds events");
  event_empty_a: assert property (!scan.buffer_nonempty |=> !raw[KIS_BIT_KEY_EVENT])
    else $error("key event flag set with empty buffer");
  clear_pulse_a: assert property (!clr_event |=> !event_buffer_clear)
    else $error("buffer clear pulse without clear write");
  sf_hold_a: assert property (!clr_wr |=> $stable(special_key_scan_disable))
    else $error("special key scan option changed without clear write");

  // Register port: writes land one edge later, reads answer one edge later.
  mask_write_a: assert property (bus.wr && bus.addr == KIS_ADDR_MASK
      |=> mask == $past(bus.wdata[3:0]))
    else $error("mask register write not stored");
  all_masked_a: assert property (mask == 4'hf |-> !irq)
    else $error("interrupt raised with every source masked");
  masked_read_a: assert property (bus.rd && bus.addr == KIS_ADDR_MASKED
      |=> rdata == {4'h0, $past(raw & ~mask)})
    else $error("masked status read mismatch");
  clear_read_a: assert property (bus.rd && bus.addr == KIS_ADDR_CLEAR
      |=> rdata == 8'h00)
    else $error("clear register did not read as zero");
  reserved_zero_a: assert property (rdata[7:4] == 4'h0)
    else $error("reserved read bits not zero");
endmodule : kis_top
`default_nettype wire

// *** kis_buffer_model.sv ***
// Behavioural model of the keypad event buffer that feeds the status block.
// Assumes one push per cycle from the bench and the block's clear pulse.
`timescale 1ns/1ns
`default_nettype none
module kis_buffer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Event push and buffer clear
  input wire logic push,
  input wire logic flush,
  // Buffer state
  output logic nonempty,
  output logic overflow
);
  logic [3:0] count;
  // The count saturates at eight, so a ninth push is the first one lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
      overflow <= 1'h0;
    end else begin
      overflow <= push && count == 4'h8;
      if (flush) begin
        count <= 4'h0;
      end else if (push && count != 4'h8) begin
        count <= count + 4'h1;
      end
    end
  end
  assign nonempty = count != 4'h0;
endmodule : kis_buffer_model
`default_nettype wire

// *** keypad_interrupt_status_bench.sv ***
// Self-checking bench for the keypad interrupt status block.
// Assumes the register port timing of the design and the event buffer model.
`timescale 1ns/1ns
`default_nettype none
module keypad_interrupt_status_bench;
  import kis_pkg::*;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic sd = 1'h0;
  logic nk = 1'h0;
  logic push = 1'h0;
  logic [3:0] kd = 4'h0;
  logic ne, ovf, ebc, sfd, irq;
  logic [7:0] rdata;
  kis_bus_t b = '0;
  kis_scan_t s;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  assign s = '{sd, sd, nk, kd, ovf, ne};
  kis_top dut (.clk(clk), .reset_n(reset_n), .bus(b), .rdata(rdata), .scan(s),
    .event_buffer_clear(ebc), .special_key_scan_disable(sfd), .irq(irq));
  kis_buffer_model model (.clk(clk), .reset_n(reset_n), .push(push), .flush(ebc),
    .nonempty(ne), .overflow(ovf));
  always #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // Strobes stand for exactly one edge, as the register port expects.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    b.wr = w;
    b.rd = !w;
    b.addr = a;
    b.wdata = d;
    idle(1);
    b.wr = 1'h0;
    b.rd = 1'h0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'h0, a, 8'h00);
    chk(rdata, exp);
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      test_done;
    end
  end
  initial begin
    idle(20);
    reset_n = 1'h1;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h09, 8'h03);
    $display("reset test done");
    sd = 1'h1;
    idle(1);
    sd = 1'h0;
    rd(8'h06, 8'h01);
    chk({7'h0, irq}, 8'h00);
    acc(1'h1, 8'h09, 8'h00);
    chk({7'h0, irq}, 8'h01);
    rd(8'h07, 8'h01);
    nk = 1'h1;
    idle(1);
    nk = 1'h0;
    rd(8'h06, 8'h03);
    acc(1'h1, 8'h08, 8'h00);
    rd(8'h06, 8'h03);
    acc(1'h1, 8'h08, 8'h01);
    rd(8'h06, 8'h00);
    kd = 4'h4;
    idle(1);
    rd(8'h06, 8'h00);
    kd = 4'h5;
    idle(1);
    kd = 4'h0;
    rd(8'h06, 8'h02);
    acc(1'h1, 8'h08, 8'h01);
    $display("scan test done");
    push = 1'h1;
    idle(8);
    rd(8'h06, 8'h04);
    idle(1);
    push = 1'h0;
    idle(2);
    rd(8'h06, 8'h0c);
    chk({7'h0, irq}, 8'h01);
    acc(1'h1, 8'h09, 8'h0f);
    chk({7'h0, irq}, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h09, 8'h0f);
    acc(1'h1, 8'h09, 8'h00);
    acc(1'h1, 8'h08, 8'h82);
    chk({6'h0, ebc, sfd}, 8'h03);
    idle(1);
    chk({7'h0, irq}, 8'h00);
    rd(8'h06, 8'h00);
    chk({7'h0, irq}, 8'h00);
    acc(1'h1, 8'h08, 8'h00);
    chk({6'h0, ebc, sfd}, 8'h00);
    $display("buffer test done");
    sd = 1'h1;
    idle(1);
    sd = 1'h0;
    acc(1'h0, 8'h0b, 8'h00);
    acc(1'h0, 8'h0c, 8'h00);
    acc(1'h0, 8'h0d, 8'h00);
    rd(8'h06, 8'h01);
    acc(1'h0, 8'h0e, 8'h00);
    idle(2);
    rd(8'h06, 8'h00);
    acc(1'h1, 8'h06, 8'hff);
    rd(8'h06, 8'h00);
    rd(8'h08, 8'h00);
    $display("code read test done");
    test_done;
  end
endmodule : keypad_interrupt_status_bench
`default_nettype wire
